// [rtl/opp_pkg.sv]
/*
  package for the otp parallel programming port: mode codes, widths,
  signature locations and reset values.
  assumes nothing of its surroundings beyond a single system clock.
*/
package opp_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CODE_DEPTH = 8192;
  localparam int CODE_AW = 13;
  localparam int ENC_DEPTH = 64;
  localparam int ENC_AW = 6;

  // mode code order: {mode_sel_a, mode_sel_b, mode_sel_c, mode_sel_d, mode_sel_e}
  localparam logic [4:0] WR_CODE = 5'h0F;
  localparam logic [4:0] WR_ENC = 5'h0D;
  localparam logic [4:0] WR_LB1 = 5'h1F;
  localparam logic [4:0] WR_LB2 = 5'h1C;
  localparam logic [4:0] WR_LB3 = 5'h16;
  localparam logic [4:0] WR_LSB = 5'h14;
  // read code order: {mode_sel_a, mode_sel_c, mode_sel_d, mode_sel_e}
  localparam logic [3:0] RD_CODE = 4'h3;
  localparam logic [3:0] RD_SIG = 4'h0;
  localparam logic [3:0] RD_LSB = 4'h1;

  localparam logic [7:0] SIG_MAKER_LOC = 8'h30;
  localparam logic [7:0] SIG_FAMILY_LOC = 8'h31;
  localparam logic [7:0] SIG_PRODUCT_LOC = 8'h60;
  localparam logic [7:0] SIG_REV_LOC = 8'h61;

  localparam int LB1_BIT = 7;
  localparam int LB2_BIT = 6;
  localparam int LB3_BIT = 5;
  localparam logic [7:0] LSB_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef struct packed {
    logic rst_hi;
    logic pse_n;
    logic strobe;
    logic vpp_hi;
    logic vcc_lvl;
    logic sel_a;
    logic sel_b_oe;
    logic sel_c;
    logic sel_d;
    logic sel_e;
  } opp_ctl_t;

  typedef enum logic [1:0] {
    OPP_IDLE,
    OPP_WRITE,
    OPP_READ
  } opp_mode_t;

endpackage

// [rtl/opp_port.sv]
/*
  otp parallel programming and verify port, device side.
  assumes all pins are asynchronous to sys_clk and are held stable by the
  programmer long enough to pass the two-stage synchronisers.
*/
// Notes on behaviour
// R1 - address bits come from low, mid, bit 14 and bit 15 address lines
// R2 - eight data lines are inputs on write, outputs on verify or read
// R3 - write modes: reset high, store enable low, vpp high, strobe pulse, mode code
// R4 - read modes: reset high, store enable low, strobe and vcc high, mode code
// R5 - encryption write takes address 0 to 3F into encryption array
// R6 - programmer sets mode, address, data, raises vpp, pulses strobe, lowers vpp
// R7 - one program pulse fully writes one byte
// R8 - further bytes repeat from address step without new mode selection
// R9 - lock byte write uses no address; address lines are ignored
// R10 - programmer verifies by stepping addresses and sampling data
// R11 - data lines driven only while mode_sel_b_output_enable is high in read modes
// R12 - lock byte read needs no address; device places byte on data lines
// R13 - no mode reads the encryption array directly
// R14 - programmer should verify after writes and fully at the end
// R15 - four fixed identification bytes at 30h, 31h, 60h, 61h
// R16 - identification bytes read with signature mode controls
// R17 - code verify outputs xnor of code byte and encryption byte by 6 address bits
// R18 - lock bits at 7 to 5 of lock byte, other bits read one
// R19 - write modes never drive the data lines
// R20 - write happens only on pulse with vpp present in a write mode
`timescale 1ns/1ps
module opp_port
  import opp_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h11,   // arbitrary value
  parameter logic [7:0] FAMILY_CODE = 8'h22,  // arbitrary value
  parameter logic [7:0] PRODUCT_CODE = 8'h33, // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h44 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic reset_pin,
  input wire logic program_store_enable_n,
  input wire logic prog_strobe_pin,
  input wire logic vpp_high_pin,
  input wire logic vcc_level_pin,
  input wire logic mode_sel_a,
  input wire logic mode_sel_b_output_enable,
  input wire logic mode_sel_c,
  input wire logic mode_sel_d,
  input wire logic mode_sel_e,
  input wire logic [7:0] low_address_lines,
  input wire logic [5:0] mid_address_lines,
  input wire logic address_bit_14_line,
  input wire logic address_bit_15_line,
  input wire logic [DATA_W-1:0] byte_data_lines,
  output logic [DATA_W-1:0] byte_data_lines_rd,
  output logic byte_data_lines_oe,
  output logic [2:0] lock_bits,
  output logic write_done
);

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  opp_ctl_t ctl_raw;
  opp_ctl_t ctl_s1_q;
  opp_ctl_t ctl_q;
  logic [ADDR_W-1:0] addr_raw;
  logic [ADDR_W-1:0] addr_s1_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] din_s1_q;
  logic [DATA_W-1:0] din_q;

  assign ctl_raw = '{rst_hi: reset_pin, pse_n: program_store_enable_n, strobe: prog_strobe_pin,
                     vpp_hi: vpp_high_pin, vcc_lvl: vcc_level_pin, sel_a: mode_sel_a,
                     sel_b_oe: mode_sel_b_output_enable, sel_c: mode_sel_c, sel_d: mode_sel_d,
                     sel_e: mode_sel_e};
  // address assembly
  assign addr_raw = {address_bit_15_line, address_bit_14_line, mid_address_lines,
                     low_address_lines}; // see R1

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctl_s1_q <= '0;
      ctl_q <= '0;
      addr_s1_q <= '0;
      addr_q <= '0;
      din_s1_q <= '0;
      din_q <= '0;
    end else if (clk_en) begin
      ctl_s1_q <= ctl_raw;
      ctl_q <= ctl_s1_q;
      addr_s1_q <= addr_raw;
      addr_q <= addr_s1_q;
      din_s1_q <= byte_data_lines;
      din_q <= din_s1_q;
    end
  end

  // ---------------------------------------------
  // mode decode
  // ---------------------------------------------
  logic [4:0] wr_sel;
  logic [3:0] rd_sel;
  logic base_ok;
  logic wr_mode;
  logic rd_mode;
  logic strobe_d1_q;
  logic pulse;

  assign wr_sel = {ctl_q.sel_a, ctl_q.sel_b_oe, ctl_q.sel_c, ctl_q.sel_d, ctl_q.sel_e};
  assign rd_sel = {ctl_q.sel_a, ctl_q.sel_c, ctl_q.sel_d, ctl_q.sel_e};
  assign base_ok = ctl_q.rst_hi && !ctl_q.pse_n;
  assign wr_mode = base_ok && ctl_q.vpp_hi && (wr_sel inside {WR_CODE, WR_ENC, WR_LB1, WR_LB2, WR_LB3, WR_LSB}); // see R3
  assign rd_mode = base_ok && !ctl_q.vpp_hi && ctl_q.vcc_lvl && ctl_q.strobe
                   && (rd_sel inside {RD_CODE, RD_SIG, RD_LSB}); // see R4
  // falling edge of the strobe is the program pulse
  assign pulse = strobe_d1_q && !ctl_q.strobe;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      strobe_d1_q <= 1'b1;
    end else if (clk_en) begin
      strobe_d1_q <= ctl_q.strobe;
    end
  end

  // ---------------------------------------------
  // arrays and lock byte
  // ---------------------------------------------
  // cells start erased; only a program pulse can clear bits
  logic [DATA_W-1:0] code_mem [CODE_DEPTH] = '{default: ERASED_BYTE};
  logic [DATA_W-1:0] enc_mem [ENC_DEPTH] = '{default: ERASED_BYTE};
  logic [2:0] lock_q;
  logic do_write;

  assign do_write = pulse && wr_mode; // see R20

  // a single pulse commits the whole byte; programming is modelled as and-ing into erased ones
  always_ff @(posedge sys_clk) begin
    if (clk_en && do_write && wr_sel == WR_CODE) begin
      code_mem[addr_q[CODE_AW-1:0]] <= code_mem[addr_q[CODE_AW-1:0]] & din_q; // see R7
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && do_write && wr_sel == WR_ENC && addr_q < ADDR_W'(ENC_DEPTH)) begin
      enc_mem[addr_q[ENC_AW-1:0]] <= enc_mem[addr_q[ENC_AW-1:0]] & din_q; // see R5
    end
  end

  // lock state is volatile in this model and erased on reset; address unused (see R9)
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lock_q <= LSB_RESET[LB1_BIT:LB3_BIT];
    end else if (clk_en && do_write) begin
      unique case (wr_sel)
        WR_LB1: lock_q[2] <= 1'b0;
        WR_LB2: lock_q[1] <= 1'b0;
        WR_LB3: lock_q[0] <= 1'b0;
        WR_LSB: lock_q <= lock_q & din_q[LB1_BIT:LB3_BIT];
        default: lock_q <= lock_q;
      endcase
    end
  end

  // ---------------------------------------------
  // read path
  // ---------------------------------------------
  logic [7:0] lock_byte;
  logic [7:0] sig_byte;
  logic [7:0] rd_byte;
  logic [DATA_W-1:0] dout_q;
  logic oe_q;
  logic done_q;

  assign lock_byte = {lock_q, LSB_RESET[LB3_BIT-1:0]}; // see R18

  always_comb begin
    unique case (addr_q[7:0])
      SIG_MAKER_LOC: sig_byte = MAKER_CODE; // see R15
      SIG_FAMILY_LOC: sig_byte = FAMILY_CODE;
      SIG_PRODUCT_LOC: sig_byte = PRODUCT_CODE;
      SIG_REV_LOC: sig_byte = REVISION_CODE;
      default: sig_byte = ERASED_BYTE;
    endcase
  end

  // the encryption array has no read mode; it shows only through code verify (see R13)
  always_comb begin
    unique case (rd_sel)
      RD_CODE: rd_byte = ~(code_mem[addr_q[CODE_AW-1:0]] ^ enc_mem[addr_q[ENC_AW-1:0]]); // see R17
      RD_SIG: rd_byte = sig_byte; // see R16
      RD_LSB: rd_byte = lock_byte; // see R12
      default: rd_byte = ERASED_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dout_q <= '0;
      oe_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      dout_q <= rd_byte;
      oe_q <= rd_mode && ctl_q.sel_b_oe && !wr_mode; // see R11 see R19 see R2
      done_q <= do_write;
    end
  end

  assign byte_data_lines_rd = dout_q;
  assign byte_data_lines_oe = oe_q;
  assign lock_bits = lock_q;
  assign write_done = done_q;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  AST_NO_DRIVE_IN_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R19
    clk_en && wr_mode |=> !byte_data_lines_oe) else $error("data lines driven in write mode");
  AST_OE_NEEDS_SEL_B: assert property (@(posedge sys_clk) disable iff (!rstn) // see R11
    byte_data_lines_oe |-> $past(ctl_q.sel_b_oe)) else $error("output enabled without select b");
  AST_DONE_NEEDS_VPP: assert property (@(posedge sys_clk) disable iff (!rstn) // see R20
    write_done |-> $past(ctl_q.vpp_hi) && $past(wr_mode)) else $error("write without vpp");
  AST_LOCK_RESERVED_ONES: assert property (@(posedge sys_clk) disable iff (!rstn) // see R18
    clk_en && rd_mode && rd_sel == RD_LSB |=> dout_q[4:0] == 5'h1F) else $error("reserved bits not one");
  AST_SIG_MAKER: assert property (@(posedge sys_clk) disable iff (!rstn) // see R15
    clk_en && rd_sel == RD_SIG && addr_q[7:0] == SIG_MAKER_LOC |=> dout_q == MAKER_CODE)
    else $error("maker code wrong");
  AST_LOCK_ONLY_CLEARS: assert property (@(posedge sys_clk) disable iff (!rstn) // see R3
    (lock_q & ~$past(lock_q)) == 3'h0) else $error("lock bit returned to one");
  AST_ONE_PULSE_DONE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R7
    clk_en && do_write |=> write_done ##1 !write_done) else $error("write not single pulse");
  AST_NO_READ_IN_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R4
    byte_data_lines_oe |-> !$past(ctl_q.vpp_hi) && $past(ctl_q.strobe)) else $error("data driven under vpp or low strobe");

endmodule

// [tb/opp_prog_model.sv]
/* programmer model: drives the port's pins and data lines.
   assumes one caller at a time and the port's own clock. */
`timescale 1ns/1ps
module opp_prog_model
  import opp_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] dev_rd,
  input wire logic dev_oe,
  output logic [15:0] addr,
  output opp_ctl_t ctl,
  output logic [7:0] bus
);
  logic drv = 1'b0;
  logic [7:0] dq = 8'h00;
  // released lines show the inverse of the last byte
  assign bus = dev_oe ? dev_rd : (drv ? dq : ~dq);
  initial begin
    addr = 16'h0000;
    ctl = 10'h2A0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // mode, then address and data, vpp up, one pulse, vpp down
  task automatic wr(input logic [4:0] m, input logic [15:0] a, input logic [7:0] d, input logic v);
    step(1);
    {ctl.sel_a, ctl.sel_b_oe, ctl.sel_c, ctl.sel_d, ctl.sel_e} = m;
    step(1);
    addr = a;
    dq = d;
    drv = 1'b1;
    ctl.vpp_hi = v;
    ctl.vcc_lvl = ~v;
    step(3);
    ctl.strobe = 1'b0;
    step(2);
    ctl.strobe = 1'b1;
    step(2);
    ctl.vpp_hi = 1'b0;
    ctl.vcc_lvl = 1'b1;
    drv = 1'b0;
  endtask
  // read: vpp off, strobe high, sel_b gates the output
  task automatic rd(input logic [3:0] m, input logic oe, input logic [15:0] a, output logic [7:0] d, output logic o);
    step(1);
    {ctl.sel_a, ctl.sel_b_oe, ctl.sel_c, ctl.sel_d, ctl.sel_e} = {m[3], oe, m[2:0]};
    addr = a;
    step(4);
    d = bus;
    o = dev_oe;
  endtask
endmodule

// [tb/tb_opp_port.sv]
/* bench for opp_port: scenario tasks drive the programmer model and judge
   the answers. assumes opp_pkg and the model are compiled first. */
`timescale 1ns/1ps
module tb_opp_port;
  import opp_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr;
  opp_ctl_t ctl;
  logic [7:0] bus;
  logic [7:0] dout;
  logic oe;
  logic [2:0] lock_bits;
  logic write_done;
  logic [7:0] d;
  logic o;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int fall_cyc = 0;
  int wd_cnt = 0;
  always #50 sys_clk = ~sys_clk;
  opp_port uut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .reset_pin(ctl.rst_hi),
    .program_store_enable_n(ctl.pse_n), .prog_strobe_pin(ctl.strobe), .vpp_high_pin(ctl.vpp_hi),
    .vcc_level_pin(ctl.vcc_lvl), .mode_sel_a(ctl.sel_a), .mode_sel_b_output_enable(ctl.sel_b_oe),
    .mode_sel_c(ctl.sel_c), .mode_sel_d(ctl.sel_d), .mode_sel_e(ctl.sel_e),
    .low_address_lines(addr[7:0]), .mid_address_lines(addr[13:8]),
    .address_bit_14_line(addr[14]), .address_bit_15_line(addr[15]), .byte_data_lines(bus),
    .byte_data_lines_rd(dout), .byte_data_lines_oe(oe), .lock_bits(lock_bits), .write_done(write_done));
  opp_prog_model prg (.clk(sys_clk), .dev_rd(dout), .dev_oe(oe), .addr(addr), .ctl(ctl), .bus(bus));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(negedge ctl.strobe) fall_cyc = cyc;
  always @(posedge sys_clk) begin
    if (write_done === 1'b1) chk("write_latency", 8'h03, 8'(cyc - fall_cyc));
    if (!ctl.strobe) chk("oe_in_write", 8'h00, {7'h00, oe});
    wd_cnt += int'(write_done === 1'b1);
    cyc++;
  end
  task automatic vfy(input logic [3:0] m, input logic [15:0] a, input logic [7:0] exp);
    prg.rd(m, 1'b1, a, d, o);
    chk("read_oe", 8'h01, {7'h00, o});
    chk("read_data", exp, d);
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    chk("lock_rst", 8'h07, {5'h00, lock_bits});
  endtask
  task automatic t_code;
    int w0;
    w0 = wd_cnt;
    prg.wr(WR_CODE, 16'h1234, 8'hA5, 1'b1);
    prg.wr(WR_CODE, 16'h1235, 8'h3C, 1'b1);
    prg.wr(WR_CODE, 16'h0100, 8'h00, 1'b0);
    chk("write_cnt", 8'h02, 8'(wd_cnt - w0));
    vfy(RD_CODE, 16'h1234, 8'hA5);
    vfy(RD_CODE, 16'h1235, 8'h3C);
    vfy(RD_CODE, 16'h0100, ERASED_BYTE);
    prg.rd(RD_CODE, 1'b0, 16'h1234, d, o);
    chk("oe_off", 8'h00, {7'h00, o});
    $display("test code done");
  endtask
  task automatic t_enc;
    prg.wr(WR_ENC, 16'h0045, 8'h00, 1'b1);
    vfy(RD_CODE, 16'h0005, ERASED_BYTE);
    prg.wr(WR_ENC, 16'h0005, 8'h0F, 1'b1);
    vfy(RD_CODE, 16'h0045, 8'h0F);
    vfy(RD_SIG, 16'h0005, ERASED_BYTE);
    $display("test encryption done");
  endtask
  task automatic t_lock;
    logic [4:0] md [3] = '{WR_LB1, WR_LB2, WR_LB3};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      prg.wr(md[i], 16'hFFFF, 8'hFF, 1'b1);
      chk("lock_bit", 8'(3'h7 ^ (3'h4 >> i)), {5'h00, lock_bits});
    end
    do_reset();
    prg.wr(WR_LSB, 16'h5A5A, 8'hC0, 1'b1);
    vfy(RD_LSB, 16'hA5A5, 8'hDF);
    $display("test lock done");
  endtask
  task automatic t_sig;
    logic [7:0] loc [5] = '{SIG_MAKER_LOC, SIG_FAMILY_LOC, SIG_PRODUCT_LOC, SIG_REV_LOC, 8'h32};
    logic [7:0] val [5] = '{8'h11, 8'h22, 8'h33, 8'h44, ERASED_BYTE};
    for (int i = 0; i < 5; i++) begin
      vfy(RD_SIG, {8'h00, loc[i]}, val[i]);
    end
    $display("test signature done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    chk("oe_rst", 8'h00, {7'h00, oe});
    chk("lock_rst", 8'h07, {5'h00, lock_bits});
    t_code();
    t_enc();
    t_lock();
    t_sig();
    report_and_stop();
  end
  initial begin
    #(5000 * 100);
    error_cnt++;
    report_and_stop();
  end
endmodule
